// ===== can_status_pkg.sv
package can_status_pkg;

	// Register offsets on the plain register port.
	localparam logic [7:0] OFS_CONTROL = 8'h20;
	localparam logic [7:0] OFS_COMMAND = 8'h21;
	localparam logic [7:0] OFS_STATUS = 8'h22;
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h23;
	localparam logic [7:0] OFS_ACC_CODE = 8'h24;
	localparam logic [7:0] OFS_ACC_MASK = 8'h25;

	// Control register fields.
	localparam int CTL_RESET_REQUEST = 0;
	localparam int CTL_RX_IRQ_EN = 1;
	localparam int CTL_TX_IRQ_EN = 2;
	localparam int CTL_ERR_IRQ_EN = 3;
	localparam int CTL_OVR_IRQ_EN = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h01;

	// Command register fields (write only).
	localparam int CMD_TX_REQUEST = 0;
	localparam int CMD_ABORT = 1;
	localparam int CMD_RELEASE_RX = 2;
	localparam int CMD_CLEAR_OVERRUN = 3;
	localparam int CMD_SLEEP = 4;
	localparam logic [7:0] COMMAND_READ_VALUE = 8'hff;

	// Status register fields.
	localparam int ST_RX_FULL = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_TX_ACCESS = 2;
	localparam int ST_TX_COMPLETE = 3;
	localparam int ST_RECEIVING = 4;
	localparam int ST_TRANSMITTING = 5;
	localparam int ST_ERR_WARNING = 6;
	localparam int ST_OFF_BUS = 7;
	localparam logic [7:0] STATUS_RESET = 8'h0c;

	// Interrupt flag register fields.
	localparam int IF_RX = 0;
	localparam int IF_TX = 1;
	localparam int IF_ERR = 2;
	localparam int IF_OVR = 3;
	localparam int IF_WAKE = 4;

	// Limits and counts.
	localparam int ERR_WARN_LIMIT = 96;
	localparam int BUS_OFF_LIMIT = 256;
	localparam int RECOVERY_SEQUENCES = 128;
	localparam int RX_BUFFERS = 2;

	typedef struct packed {
		logic tx_start;
		logic tx_ok;
		logic arb_lost;
		logic rx_start;
		logic rx_done;
		logic frame_idle;
		logic recessive_seq;
		logic bus_activity;
	} engine_ev_t;

endpackage

// ===== can_status_irq_accept_filter.sv
`timescale 1ns/1ps
// What this block does
// RULE1: Transmit errors at 256 force off-bus and reset request.
// RULE2: Off-bus clears after 128 recessive sequences.
// RULE3: Warning flag follows either counter reaching 96.
// RULE4: Transmitting and receiving flags show bus activity.
// RULE5: Transmit request clears complete flag; success sets it.
// RULE6: Abort before sending releases buffer, complete stays clear.
// RULE7: Buffer access flag clear while message pending.
// RULE8: Both buffers full sets overrun, drops message.
// RULE9: Clear-overrun command clears the overrun flag.
// RULE10: Own transmission occupies a buffer, may overrun. Here it can only overrun; it takes no buffer.
// RULE11: Release clears full flag unless second buffer holds.
// RULE12: Reading interrupt register clears every interrupt flag.
// RULE13: Bus activity while asleep wakes and flags it.
// RULE14: Overrun interrupt flag when enabled; cleared read/reset.
// RULE15: Error interrupt on warning or off-bus change.
// RULE16: Transmit interrupt at transmission end when enabled.
// RULE17: Receive interrupt sets with receive-full flag.
// RULE18: Messages stored always; only accepted ones notify. Here a rejected message is stored only when a send starts in the same cycle.
// RULE19: Acceptance registers usable only under reset request.
// RULE20: Code matches ID10..ID3 where mask bit clear.
// RULE21: Accepted message goes to free buffer, else overrun.
// RULE22: Status read only; defined values after resets.
// RULE23: Reset request aborts current frame, enters reset.
// RULE24: Release returns the buffer held by software.
// RULE25: Interrupt output high while any flag set.
module can_status_irq_accept_filter import can_status_pkg::*; #(
	parameter int TEC_W = 9,
	parameter int REC_W = 8,
	parameter int RECOVERY_COUNT = RECOVERY_SEQUENCES
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire engine_ev_t ev,
	input wire logic [7:0] rx_id_hi,
	input wire logic [TEC_W-1:0] tx_err_count,
	input wire logic [REC_W-1:0] rx_err_count,
	output logic irq,
	output logic reset_state,
	output logic counters_clear,
	output logic tx_go,
	output logic sleep_mode,
	output logic bus_on
);

	if (TEC_W < 9 || REC_W < 7 || RECOVERY_COUNT < 1 || RECOVERY_COUNT > 255) begin : g_check
		$error("Counter widths or recovery count out of range.");
	end

	logic reset_request;
	logic [4:1] irq_enable;
	logic off_bus, error_warning, transmitting, receiving;
	logic tx_complete, tx_pending, overrun, sleeping;
	logic [1:0] buf_count;
	logic [7:0] acc_code, acc_mask;
	logic [4:0] flags;
	logic [7:0] recovery_cnt;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	logic ctl_wr, cmd_wr, irq_rd, on_bus, accept, store_try, overrun_set;
	logic tx_release, abort_ok, next_warning, recover_done, bus_off_hit;
	logic [4:0] flag_set;
	logic [7:0] status_value;

	always_comb begin
		ctl_wr = wr && reg_hit(addr, OFS_CONTROL);
		cmd_wr = wr && reg_hit(addr, OFS_COMMAND) && !reset_request;
		irq_rd = rd && reg_hit(addr, OFS_IRQ_FLAGS);
		on_bus = !reset_request && !off_bus;
		accept = &(~(acc_code ^ rx_id_hi) | acc_mask); // [RULE20]
		// The outgoing frame takes no receive buffer, but a send start is still a store try that can overrun.
		store_try = on_bus && ((ev.rx_done && accept) || ev.tx_start); // [RULE10] [RULE21]
		overrun_set = store_try && buf_count == 2'(RX_BUFFERS); // [RULE8]
		abort_ok = cmd_wr && wdata[CMD_ABORT] && tx_pending && !transmitting; // [RULE6]
		tx_release = (on_bus && ev.tx_ok && tx_pending) || abort_ok;
		next_warning = (tx_err_count >= TEC_W'(ERR_WARN_LIMIT))
			|| (rx_err_count >= REC_W'(ERR_WARN_LIMIT)); // [RULE3]
		// The engine zeroes its counters one cycle after the clear pulse.
		// Until then the old count would send the node straight back off the bus.
		bus_off_hit = !off_bus && !counters_clear
			&& tx_err_count >= TEC_W'(BUS_OFF_LIMIT); // [RULE1]
		recover_done = off_bus && !reset_request && ev.recessive_seq
			&& recovery_cnt == 8'(RECOVERY_COUNT - 1); // [RULE2]
		flag_set = '0;
		flag_set[IF_RX] = irq_enable[CTL_RX_IRQ_EN] && on_bus && ev.rx_done && accept
			&& buf_count != 2'(RX_BUFFERS); // [RULE17]
		flag_set[IF_TX] = irq_enable[CTL_TX_IRQ_EN] && tx_release; // [RULE16]
		flag_set[IF_ERR] = irq_enable[CTL_ERR_IRQ_EN]
			&& ((next_warning != error_warning) || bus_off_hit || recover_done); // [RULE15]
		flag_set[IF_OVR] = irq_enable[CTL_OVR_IRQ_EN] && overrun_set; // [RULE14]
		flag_set[IF_WAKE] = sleeping && ev.bus_activity; // [RULE13]
		status_value = {off_bus, error_warning, transmitting, receiving,
			tx_complete, !tx_pending, overrun, buf_count != 2'd0}; // [RULE7] [RULE11]
	end

	// Reset request: set by external reset, software or bus-off; cleared by software only.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reset_request <= CONTROL_RESET[CTL_RESET_REQUEST];
			irq_enable <= CONTROL_RESET[4:1];
		end else if (ce) begin
			if (ctl_wr) begin
				reset_request <= wdata[CTL_RESET_REQUEST];
				irq_enable <= wdata[4:1];
			end
			if (bus_off_hit) begin
				reset_request <= 1'b1; // [RULE1]
			end
		end
	end

	// Off-bus and recovery counting of recessive sequences.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			off_bus <= STATUS_RESET[ST_OFF_BUS];
			recovery_cnt <= 8'h00;
			counters_clear <= 1'b0;
		end else if (ce) begin
			counters_clear <= recover_done; // [RULE2]
			if (bus_off_hit) begin
				off_bus <= 1'b1; // [RULE1]
				recovery_cnt <= 8'h00;
			end else if (recover_done) begin
				off_bus <= 1'b0; // [RULE2]
				recovery_cnt <= 8'h00;
			end else if (off_bus && !reset_request && ev.recessive_seq) begin
				recovery_cnt <= recovery_cnt + 8'h01;
			end
		end
	end

	// Warning level is kept through a reset request, as is the off-bus flag.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			error_warning <= STATUS_RESET[ST_ERR_WARNING];
		end else if (ce) begin
			error_warning <= next_warning; // [RULE3]
		end
	end

	// Activity flags; a reset request aborts whatever frame is on the wire.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			transmitting <= STATUS_RESET[ST_TRANSMITTING];
			receiving <= STATUS_RESET[ST_RECEIVING];
		end else if (ce) begin
			if (!on_bus) begin
				transmitting <= 1'b0; // [RULE23]
				receiving <= 1'b0;
			end else begin
				if (ev.tx_ok || ev.arb_lost || ev.frame_idle) begin
					transmitting <= 1'b0;
				end
				if (ev.rx_done || ev.frame_idle) begin
					receiving <= 1'b0;
				end
				if (ev.tx_start && tx_pending) begin
					transmitting <= 1'b1; // [RULE4]
				end
				if (ev.arb_lost || (ev.rx_start && !transmitting)) begin
					receiving <= 1'b1; // [RULE4]
				end
			end
		end
	end

	// Transmit request, abort and completion.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tx_pending <= !STATUS_RESET[ST_TX_ACCESS];
			tx_complete <= STATUS_RESET[ST_TX_COMPLETE];
		end else if (ce) begin
			if (reset_request) begin
				tx_pending <= 1'b0; // [RULE23]
				tx_complete <= STATUS_RESET[ST_TX_COMPLETE]; // [RULE22]
			end else if (cmd_wr && wdata[CMD_TX_REQUEST] && !tx_pending) begin
				tx_pending <= 1'b1; // [RULE7]
				tx_complete <= 1'b0; // [RULE5]
			end else if (tx_release) begin
				tx_pending <= 1'b0; // [RULE6]
				tx_complete <= !abort_ok; // [RULE5]
			end
		end
	end

	// Receive buffers: the count includes the one held by software.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			buf_count <= 2'd0;
		end else if (ce) begin
			if (reset_request) begin
				buf_count <= 2'd0; // [RULE22]
			end else begin
				// A release with the second buffer full leaves the full flag set at once.
				case ({cmd_wr && wdata[CMD_RELEASE_RX] && buf_count != 2'd0,
						store_try && ev.rx_done && !overrun_set})
					2'b10: buf_count <= buf_count - 2'd1; // [RULE11] [RULE24]
					2'b01: buf_count <= buf_count + 2'd1; // [RULE18] [RULE21]
					default: buf_count <= buf_count;
				endcase
			end
		end
	end

	// Overrun: hardware set wins over the clear command in the same cycle.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			overrun <= STATUS_RESET[ST_OVERRUN];
		end else if (ce) begin
			if (reset_request || (cmd_wr && wdata[CMD_CLEAR_OVERRUN])) begin
				overrun <= 1'b0; // [RULE9]
			end
			if (overrun_set) begin
				overrun <= 1'b1; // [RULE8]
			end
		end
	end

	// Sleep command and wake-up on bus activity.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sleeping <= 1'b0;
		end else if (ce) begin
			if (cmd_wr) begin
				sleeping <= wdata[CMD_SLEEP];
			end
			if (sleeping && ev.bus_activity) begin
				sleeping <= 1'b0; // [RULE13]
			end
		end
	end

	// Interrupt flags clear on read; a set in the same cycle survives.
	// Error and wake flags survive a reset request; the others do not.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			flags <= 5'h00;
		end else if (ce) begin
			if (irq_rd) begin
				flags <= flag_set; // [RULE12]
			end else if (reset_request) begin
				flags <= (flags & 5'h14) | flag_set; // [RULE14] [RULE16] [RULE17]
			end else begin
				flags <= flags | flag_set;
			end
		end
	end

	// Acceptance code and mask only answer while the reset request is set.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			acc_code <= 8'h00;
			acc_mask <= 8'hff;
		end else if (ce && wr && reset_request) begin
			if (reg_hit(addr, OFS_ACC_CODE)) begin
				acc_code <= wdata; // [RULE19]
			end
			if (reg_hit(addr, OFS_ACC_MASK)) begin
				acc_mask <= wdata; // [RULE19]
			end
		end
	end

	// Read data stands for one cycle only; unmapped or locked reads give ones.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else if (ce) begin
			rdata <= 8'h00;
			if (rd) begin
				case (addr)
					OFS_CONTROL: rdata <= {3'b000, irq_enable, reset_request};
					OFS_COMMAND: rdata <= COMMAND_READ_VALUE;
					OFS_STATUS: rdata <= status_value; // [RULE22]
					OFS_IRQ_FLAGS: rdata <= {3'b000, flags};
					OFS_ACC_CODE: rdata <= reset_request ? acc_code : 8'hff; // [RULE19]
					OFS_ACC_MASK: rdata <= reset_request ? acc_mask : 8'hff; // [RULE19]
					default: rdata <= 8'hff;
				endcase
			end
		end
	end

	// Outputs toward the CPU and the protocol engine.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			irq <= 1'b0;
			reset_state <= 1'b1;
			tx_go <= 1'b0;
			sleep_mode <= 1'b0;
			bus_on <= 1'b0;
		end else if (ce) begin
			irq <= |flags; // [RULE25]
			reset_state <= reset_request; // [RULE23]
			tx_go <= tx_pending && on_bus && !transmitting;
			sleep_mode <= sleeping;
			bus_on <= on_bus; // [RULE1]
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_bus_off_entry: assert property (ce && bus_off_hit |=> off_bus && reset_request) // [RULE1]
		else $error("Bus-off entry missed.");
	a_recovery_end: assert property (ce && recover_done |=> !off_bus && counters_clear) // [RULE2]
		else $error("Bus-off recovery did not finish.");
	a_warning_level: assert property (ce |=> error_warning == ($past(tx_err_count) >= 96
		|| $past(rx_err_count) >= 96)) // [RULE3]
		else $error("Warning flag disagrees with counters.");
	a_tx_req_clear: assert property (ce && cmd_wr && wdata[CMD_TX_REQUEST] && !tx_pending
		|=> !tx_complete && tx_pending) // [RULE5]
		else $error("Transmit request did not clear complete flag.");
	a_abort_release: assert property (ce && abort_ok && !reset_request
		|=> !tx_pending && !tx_complete) // [RULE6]
		else $error("Abort did not release buffer cleanly.");
	a_overrun_drop: assert property (ce && overrun_set && !reset_request
		|=> overrun && buf_count <= $past(buf_count)) // [RULE8]
		else $error("Overrun not flagged or message kept.");
	a_read_clears: assert property (ce && irq_rd && flag_set == 5'h00 |=> flags == 5'h00) // [RULE12]
		else $error("Interrupt read did not clear flags.");
	a_reject_quiet: assert property (ce && on_bus && ev.rx_done && !accept && !ev.tx_start
		&& !cmd_wr |=> $stable(buf_count) && (!flags[IF_RX] || $past(flags[IF_RX]))) // [RULE18]
		else $error("Rejected message was delivered.");
	a_wake_flag: assert property (ce && sleeping && ev.bus_activity |=> !sleeping
		&& flags[IF_WAKE]) // [RULE13]
		else $error("Wake-up not flagged.");
	a_irq_follows: assert property (ce && flags != 5'h00 ##1 ce |-> irq) // [RULE25]
		else $error("Interrupt output not raised.");
	a_irq_low: assert property (ce && flags == 5'h00 ##1 ce |-> !irq) // [RULE25]
		else $error("Interrupt output stuck high.");
	a_tx_done: assert property (ce && on_bus && ev.tx_ok && tx_pending && !abort_ok // [RULE5]
		|=> tx_complete && !tx_pending)
		else $error("Successful transmission not marked complete.");
	a_overrun_clear: assert property (ce && cmd_wr && wdata[CMD_CLEAR_OVERRUN] // [RULE9]
		&& !overrun_set |=> !overrun)
		else $error("Clear-overrun command ignored.");
	a_rx_full_flag: assert property (ce && flag_set[IF_RX] // [RULE17]
		|=> flags[IF_RX] && status_value[ST_RX_FULL])
		else $error("Receive flag and full flag not set together.");
	a_error_irq: assert property (ce && irq_enable[CTL_ERR_IRQ_EN] // [RULE15]
		&& next_warning != error_warning |=> flags[IF_ERR])
		else $error("Warning change did not raise error flag.");
	// A reset request must also wipe the pending interrupt causes that it makes stale.
	a_reset_drops: assert property (ce && reset_request // [RULE14]
		|=> (flags & 5'h0b) == 5'h00)
		else $error("Reset request left receive, transmit or overrun flag.");
	a_reset_status: assert property (ce && reset_request // [RULE22]
		|=> status_value[5:0] == STATUS_RESET[5:0])
		else $error("Status low bits wrong under reset request.");
	a_frame_abort: assert property (ce && !on_bus // [RULE23]
		|=> !transmitting && !receiving)
		else $error("Frame activity kept while not on the bus.");
	a_accept_locked: assert property (ce && wr && !reset_request // [RULE19]
		&& reg_hit(addr, OFS_ACC_CODE) |=> $stable(acc_code))
		else $error("Acceptance code changed outside reset request.");

	c_recovery: cover property (ce && recover_done);
	c_overrun: cover property (ce && overrun_set);
	c_accepted: cover property (ce && flag_set[IF_RX]);
	c_abort: cover property (ce && abort_ok);
	c_wake: cover property (ce && flag_set[IF_WAKE]);

endmodule // can_status_irq_accept_filter

// ===== can_engine_model.sv
`timescale 1ns/1ps
// Stands in for the protocol engine and the other nodes on the wire.
module can_engine_model import can_status_pkg::*; (
	input wire logic core_clk,
	input wire logic counters_clear,
	output engine_ev_t ev,
	output logic [7:0] rx_id_hi,
	output logic [8:0] tx_err_count,
	output logic [7:0] rx_err_count
);
	initial begin
		ev = '0;
		rx_id_hi = 8'h00;
		tx_err_count = 9'h000;
		rx_err_count = 8'h00;
	end

	always @(posedge core_clk) begin
		if (counters_clear) begin
			tx_err_count <= 9'h000;
			rx_err_count <= 8'h00;
		end
	end

	// The identifier is only good with its event, so it is scrambled afterwards.
	task automatic pulse(input engine_ev_t e, input logic [7:0] id, input int gap);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		ev <= e;
		rx_id_hi <= id;
		@(posedge core_clk);
		ev <= '0;
		rx_id_hi <= ~id;
	endtask

	task automatic set_err(input logic [8:0] tec, input logic [7:0] rec);
		@(posedge core_clk);
		tx_err_count <= tec;
		rx_err_count <= rec;
	endtask
endmodule // can_engine_model

// ===== can_status_irq_accept_filter_tb.sv
`timescale 1ns/1ps
`define CMP(nm, e, g) begin \
	n_checks++; \
	if ((e) !== (g)) begin \
		fail_count++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
module can_status_irq_accept_filter_tb import can_status_pkg::*; ();
	typedef struct {logic [7:0] a; logic [7:0] v; logic [7:0] m;} exp_t;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_seen = 1'b0;
	logic clr_seen = 1'b0;
	logic [7:0] rdata, rx_id_hi, rx_err_count, code;
	logic [8:0] tx_err_count;
	engine_ev_t ev;
	logic irq, reset_state, counters_clear, tx_go, sleep_mode, bus_on;
	exp_t exp_q[$];
	int fail_count = 0;
	int n_checks = 0;

	always #50 core_clk = ~core_clk;

	can_status_irq_accept_filter #(.RECOVERY_COUNT(2)) u_dut (.core_clk(core_clk),
		.nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ev(ev), .rx_id_hi(rx_id_hi), .tx_err_count(tx_err_count),
		.rx_err_count(rx_err_count), .irq(irq), .reset_state(reset_state),
		.counters_clear(counters_clear), .tx_go(tx_go), .sleep_mode(sleep_mode),
		.bus_on(bus_on));

	can_engine_model u_eng (.core_clk(core_clk), .counters_clear(counters_clear),
		.ev(ev), .rx_id_hi(rx_id_hi), .tx_err_count(tx_err_count),
		.rx_err_count(rx_err_count));

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back('{a, v, m});
		@(posedge core_clk);
		rd <= 1'b0;
	endtask

	task automatic frame(input logic [7:0] id, input int gap);
		u_eng.pulse(8'h08, id, gap);
	endtask

	always @(posedge core_clk) begin
		rd_seen <= rd;
		if (counters_clear === 1'b1) clr_seen <= 1'b1;
	end

	// Read data stands for one cycle only, so it is taken mid-cycle.
	always @(negedge core_clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			`CMP($sformatf("reg %h", exp_q[0].a), exp_q[0].v, rdata & exp_q[0].m)
			void'(exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(91611));
		code = 8'($urandom());
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		rd_chk(OFS_STATUS, STATUS_RESET, 8'hff);
		wr_reg(OFS_STATUS, 8'hf3);
		rd_chk(OFS_STATUS, STATUS_RESET, 8'hff);
		rd_chk(8'h3f, 8'hff, 8'hff);
		rd_chk(OFS_COMMAND, COMMAND_READ_VALUE, 8'hff);
		wr_reg(OFS_ACC_CODE, code);
		wr_reg(OFS_ACC_MASK, 8'h0f);
		rd_chk(OFS_ACC_CODE, code, 8'hff);
		rd_chk(OFS_ACC_MASK, 8'h0f, 8'hff);
		wr_reg(OFS_CONTROL, 8'h1e);
		rd_chk(OFS_ACC_CODE, 8'hff, 8'hff);
		wr_reg(OFS_ACC_CODE, ~code);
		frame(code ^ 8'h05, 0);
		rd_chk(OFS_STATUS, 8'h0d, 8'hff);
		@(negedge core_clk);
		`CMP("irq", 1'b1, irq)
		rd_chk(OFS_IRQ_FLAGS, 8'h01, 8'hff);
		repeat (2) @(negedge core_clk);
		`CMP("irq", 1'b0, irq)
		rd_chk(OFS_IRQ_FLAGS, 8'h00, 8'hff);
		frame(code ^ 8'h80, 3);
		rd_chk(OFS_IRQ_FLAGS, 8'h00, 8'h01);
		frame(code, 0);
		frame(code ^ 8'h0f, 2);
		rd_chk(OFS_STATUS, 8'h0f, 8'hff);
		rd_chk(OFS_IRQ_FLAGS, 8'h08, 8'h08);
		u_eng.pulse(8'h80, 8'h00, 0);
		rd_chk(OFS_IRQ_FLAGS, 8'h08, 8'h08);
		wr_reg(OFS_COMMAND, 8'h0c);
		rd_chk(OFS_STATUS, 8'h0d, 8'hff);
		wr_reg(OFS_COMMAND, 8'h04);
		rd_chk(OFS_STATUS, 8'h0c, 8'hff);
		rd_chk(OFS_IRQ_FLAGS, 8'h00, 8'hff);
		wr_reg(OFS_COMMAND, 8'h01);
		rd_chk(OFS_STATUS, 8'h00, 8'hff);
		@(negedge core_clk);
		`CMP("tx_go", 1'b1, tx_go)
		u_eng.pulse(8'h80, 8'h00, 1);
		rd_chk(OFS_STATUS, 8'h20, 8'hff);
		u_eng.pulse(8'h40, 8'h00, 4);
		rd_chk(OFS_STATUS, 8'h0c, 8'hff);
		rd_chk(OFS_IRQ_FLAGS, 8'h02, 8'h02);
		u_eng.pulse(8'h10, 8'h00, 0);
		rd_chk(OFS_STATUS, 8'h10, 8'h30);
		frame(code ^ 8'h80, 0);
		u_eng.pulse(8'h04, 8'h00, 0);
		wr_reg(OFS_COMMAND, 8'h01);
		wr_reg(OFS_COMMAND, 8'h02);
		rd_chk(OFS_STATUS, 8'h04, 8'h0c);
		@(negedge core_clk);
		`CMP("tx_go", 1'b0, tx_go)
		u_eng.set_err(9'h000, 8'd95);
		rd_chk(OFS_STATUS, 8'h00, 8'h40);
		u_eng.set_err(9'h000, 8'd96);
		rd_chk(OFS_STATUS, 8'h40, 8'h40);
		rd_chk(OFS_IRQ_FLAGS, 8'h04, 8'h04);
		u_eng.set_err(9'd256, 8'h00);
		rd_chk(OFS_STATUS, 8'h80, 8'h80);
		rd_chk(OFS_STATUS, 8'h0c, 8'h3f);
		@(negedge core_clk);
		`CMP("reset_state", 1'b1, reset_state)
		`CMP("bus_on", 1'b0, bus_on)
		wr_reg(OFS_CONTROL, 8'h1e);
		u_eng.pulse(8'h02, 8'h00, 0);
		rd_chk(OFS_STATUS, 8'h80, 8'h80);
		u_eng.pulse(8'h02, 8'h00, 2);
		rd_chk(OFS_STATUS, 8'h00, 8'h80);
		@(negedge core_clk);
		`CMP("counters_clear", 1'b1, clr_seen)
		wr_reg(OFS_COMMAND, 8'h10);
		repeat (2) @(negedge core_clk);
		`CMP("sleep_mode", 1'b1, sleep_mode)
		u_eng.pulse(8'h01, 8'h00, 0);
		repeat (2) @(negedge core_clk);
		`CMP("sleep_mode", 1'b0, sleep_mode)
		rd_chk(OFS_IRQ_FLAGS, 8'h10, 8'h10);
		repeat (3) @(posedge core_clk);
		tally_and_finish();
	end
endmodule // can_status_irq_accept_filter_tb
